// ### logic/cat_loader_defs.vh
// Constants for the channel activity table loader.
// Assumes a single 100 MHz system clock and a word-wide shared memory port.
`ifndef CAT_LOADER_DEFS_VH
`define CAT_LOADER_DEFS_VH
// Table sizes and base addresses
`define CAT_PRI_ENTRIES 128
`define CAT_GEN_ENTRIES 256
`define CAT_PRI_BASE 16'h0100
`define CAT_GEN_BASE 16'h0200
`define CAT_BUF_BASE 16'h0400
// Table word layout
`define CAT_DIR_BIT 16
`define CAT_ADDR_LSB 8
`define CAT_DIR_RX 1'b0
`define CAT_DIR_TX 1'b1
// Line/device numbering (octal 400 and 500 line units, octal 20 typewriter)
`define CAT_LINE_UNIT1 9'h100
`define CAT_LINE_UNIT2 9'h140
`define CAT_TYPEWRITER 9'h010
`define CAT_TAPE 9'h000
`endif

// ### logic/cat_loader.v
// Channel activity table loader: scans line groups and low-speed devices,
// writes tagged entries into two cyclic tables, serves transmit characters.
// Assumes line modules are on another clock (synchronised here) and that the
// memory arbiter grants the shared bus with memGnt for one-word accesses.
// Notes on behaviour
// [RQ1] Up to 128 receive and 128 transmit lines, 16 groups, 16 duplex devices.
// [RQ2] Line modules hold one character; messages build up in core memory.
// [RQ3] Two cyclic tables in memory: 128 and 256 entries.
// [RQ4] Priority table takes high-speed transmit requests; general table all else.
// [RQ5] Load pointer gives the write address, then advances by one.
// [RQ6] Each table has its own unload pointer, advanced by the program.
// [RQ7] All four pointers reset on controller clear or paper-tape load.
// [RQ8] Software places each line's next character in the buffer table.
// [RQ9] Transmit available signal halts both scanners at their position.
// [RQ10] Halted positions form buffer-table address; character goes to module.
// [RQ11] After delivery, write output request, advance pointer, release scanners.
// [RQ12] Full receive character: stop, write char and line to general table.
// [RQ13] Low-speed devices use sixteen channels, handled like line characters.
// [RQ14] Scanner address zero is paper tape; octal 20 is typewriter.
// [RQ15] Characters up to 8 bits; receive parity passed through unchecked.
// [RQ16] Entry: unused byte, direction flag, address, character (zero on output).
// [RQ17] Octal addresses 40-360 devices, 400-477 unit one, 500-577 unit two.
// [RQ18] Addresses below octal 400 have four low bits zero.
// [RQ19] Core memory bus is shared in time with processor and block I/O.
// [RQ20] Each written word is 32 data bits plus one parity bit.
// [RQ21] Pointers wrap to first entry; scanners resume after serviced slot.
`timescale 1ns/1ps
`include "cat_loader_defs.vh"

module cat_loader (
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Controller clear and paper-tape load controls
   input wire ctlClear,
   input wire tapeLoad,
   // Program unload strobes
   input wire priUnloadStep,
   input wire genUnloadStep,
   // Scanned source flags: 144 slots (128 lines, 16 devices)
   input wire [143:0] rxReady,
   input wire [143:0] txAvail,
   input wire [143:0] txHighSpeed,
   input wire [8*144-1:0] rxCharBus,
   // Shared memory port
   output reg memReq,
   output reg memWe,
   output reg [15:0] memAddr,
   output reg [32:0] memWdata,
   input wire [31:0] memRdata,
   input wire memGnt,
   // Delivery back to modules
   output reg [7:0] txChar,
   output reg txLoad,
   output reg rxTaken,
   output reg [7:0] svcSlot,
   // Pointers visible to the program
   output reg [6:0] priLoadPtr,
   output reg [7:0] genLoadPtr,
   output reg [6:0] priUnloadPtr,
   output reg [7:0] genUnloadPtr
);
   localparam NSLOT = 144;
   localparam S_SCAN = 3'd0;
   localparam S_RD = 3'd1;
   localparam S_DLV = 3'd2;
   localparam S_WR = 3'd3;
   localparam S_REL = 3'd4;

   // Slot index to line/device address: lines 0..127, devices 128..143
   function [8:0] slot_addr;
      input [7:0] s;
      begin
         if (s[7] == 1'b0)
            slot_addr = `CAT_LINE_UNIT1 + {2'b00, s[6:0]}; // RQ17
         else
            slot_addr = {1'b0, s[3:0], 4'h0}; // RQ18 RQ14 RQ13
      end
   endfunction

   // Two-flop synchronisers on module flags
   reg [143:0] rxS1, rxS2, txS1, txS2, hsS1, hsS2;
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         rxS1 <= {NSLOT{1'b0}};
         rxS2 <= {NSLOT{1'b0}};
         txS1 <= {NSLOT{1'b0}};
         txS2 <= {NSLOT{1'b0}};
         hsS1 <= {NSLOT{1'b0}};
         hsS2 <= {NSLOT{1'b0}};
      end else begin
         rxS1 <= rxReady;
         rxS2 <= rxS1;
         txS1 <= txAvail;
         txS2 <= txS1;
         hsS1 <= txHighSpeed;
         hsS2 <= hsS1;
      end
   end

   reg [2:0] state_q;
   reg [7:0] scan_q;
   reg isTx_q;
   reg toPri_q;
   reg [7:0] rxChar_q;
   reg [7:0] hold_q;
   wire [8:0] curAddr = slot_addr(scan_q);
   wire [7:0] nextScan = (scan_q == NSLOT - 1) ? 8'h00 : scan_q + 8'h01; // RQ21
   // Character byte lane of the buffer table word, chosen by low address bits
   wire [7:0] bufByte = memRdata[8*svcSlot[1:0] +: 8];
   // Data word and parity (odd parity over 32 bits)
   wire [31:0] entry = {8'h00, 7'h00, isTx_q, curAddr[7:0], // RQ16
      isTx_q ? 8'h00 : rxChar_q};
   wire clearPtr = ctlClear | tapeLoad;

   // Scanner, memory sequencing and pointers
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q <= S_SCAN;
         scan_q <= 8'h00;
         isTx_q <= 1'b0;
         toPri_q <= 1'b0;
         rxChar_q <= 8'h00;
         hold_q <= 8'h00;
         memReq <= 1'b0;
         memWe <= 1'b0;
         memAddr <= 16'h0000;
         memWdata <= 33'h0_0000_0000;
         txChar <= 8'h00;
         txLoad <= 1'b0;
         rxTaken <= 1'b0;
         svcSlot <= 8'h00;
         priLoadPtr <= 7'h00;
         genLoadPtr <= 8'h00;
         priUnloadPtr <= 7'h00;
         genUnloadPtr <= 8'h00;
      end else begin
         txLoad <= 1'b0;
         rxTaken <= 1'b0;
         // Unload pointers step only on program request; clear or tape load zeroes them
         if (clearPtr) begin
            priUnloadPtr <= 7'h00; // RQ7
            genUnloadPtr <= 8'h00;
         end else begin
            if (priUnloadStep)
               priUnloadPtr <= priUnloadPtr + 7'h01; // RQ6 RQ21
            if (genUnloadStep)
               genUnloadPtr <= genUnloadPtr + 8'h01;
         end
         if (clearPtr) begin
            // Clear aborts any access in progress; scanners restart at zero
            priLoadPtr <= 7'h00; // RQ7
            genLoadPtr <= 8'h00;
            state_q <= S_SCAN;
            scan_q <= 8'h00;
            memReq <= 1'b0;
            memWe <= 1'b0;
         end else begin
            case (state_q)
               S_SCAN: begin
                  // Hold position when a module needs service
                  if (txS2[scan_q]) begin // RQ9
                     isTx_q <= 1'b1;
                     toPri_q <= hsS2[scan_q]; // RQ4
                     svcSlot <= scan_q;
                     memReq <= 1'b1; // RQ19
                     memWe <= 1'b0;
                     memAddr <= `CAT_BUF_BASE + {8'h00, scan_q}; // RQ10 RQ8
                     state_q <= S_RD;
                  end else if (rxS2[scan_q]) begin // RQ12
                     isTx_q <= 1'b0;
                     toPri_q <= 1'b0;
                     svcSlot <= scan_q;
                     rxChar_q <= rxCharBus[8*scan_q +: 8]; // RQ15 RQ2
                     rxTaken <= 1'b1;
                     state_q <= S_WR;
                  end else
                     scan_q <= nextScan;
               end
               S_RD: begin
                  if (memGnt) begin
                     memReq <= 1'b0;
                     hold_q <= bufByte;
                     state_q <= S_DLV;
                  end
               end
               S_DLV: begin
                  txChar <= hold_q; // RQ10
                  txLoad <= 1'b1;
                  state_q <= S_WR;
               end
               S_WR: begin
                  // Issue the table write with pointer as address
                  memReq <= 1'b1;
                  memWe <= 1'b1;
                  memWdata <= {entry, ~^entry}; // RQ20
                  if (toPri_q)
                     memAddr <= `CAT_PRI_BASE + {9'h000, priLoadPtr}; // RQ5 RQ3
                  else
                     memAddr <= `CAT_GEN_BASE + {8'h00, genLoadPtr};
                  if (memReq && memWe && memGnt) begin
                     memReq <= 1'b0;
                     memWe <= 1'b0;
                     if (toPri_q)
                        priLoadPtr <= priLoadPtr + 7'h01; // RQ11 RQ21
                     else
                        genLoadPtr <= genLoadPtr + 8'h01; // RQ12
                     state_q <= S_REL;
                  end
               end
               S_REL: begin
                  // Wait for the module flag to drop through the synchroniser
                  if (!txS2[svcSlot] && !rxS2[svcSlot]) begin
                     scan_q <= nextScan; // RQ21 RQ11
                     state_q <= S_SCAN;
                  end
               end
               default:
                  state_q <= S_SCAN;
            endcase
         end
      end
   end
endmodule

// ### tb/cat_loader_monitor.sv
// Port checker for the activity table loader.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module cat_loader_monitor (
   // Clock, reset, controls
   input logic clk_sys, rst_n, ctlClear, tapeLoad, genUnloadStep,
   // Memory port and delivery
   input logic memReq, memWe, memGnt, txLoad, rxTaken,
   input logic [15:0] memAddr,
   input logic [32:0] memWdata,
   input logic [31:0] memRdata,
   input logic [8*144-1:0] rxCharBus,
   input logic [7:0] txChar, svcSlot, genLoadPtr, genUnloadPtr,
   input logic [6:0] priLoadPtr, priUnloadPtr
);
   // Selected read lane and received byte of the slot in service
   wire [7:0] lane = 8'(memRdata >> {svcSlot[1:0], 3'b000});
   wire [7:0] rxByte = 8'(rxCharBus >> {svcSlot, 3'b000});
   wire clr = ctlClear || tapeLoad;
   sequence rdDone; memReq && !memWe && memGnt && !clr; endsequence
   sequence wrDone; memReq && memWe && memGnt && !clr; endsequence
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_REQ_HOLD: assert property (memReq && !memGnt && !clr |=> memReq && $stable(memAddr))
      else $error("request dropped early");
   AST_BUF_ADDR: assert property (memReq && !memWe |-> memAddr == 16'h0400 + svcSlot)
      else $error("buffer address wrong");
   AST_TX_CHAR: assert property (rdDone |-> ##2 txLoad && txChar == $past(lane, 2))
      else $error("transmit char wrong");
   AST_TX_WRITE: assert property (txLoad |=> memReq && memWe && memWdata[17] && memWdata[8:1] == 8'h00)
      else $error("output request wrong");
   AST_WORD: assert property (memReq && memWe |-> ^memWdata && memWdata[32:18] == 15'h0000)
      else $error("table word wrong");
   AST_RX_ENTRY: assert property (rxTaken |-> ##[0:2] memReq && memWe && !memWdata[17] && memWdata[8:1] == rxByte)
      else $error("receive entry wrong");
   AST_PRI_STEP: assert property (wrDone ##0 memAddr == 16'h0100 + priLoadPtr |=> priLoadPtr == $past(priLoadPtr) + 7'h01)
      else $error("priority pointer step");
   AST_GEN_STEP: assert property (wrDone ##0 memAddr == 16'h0200 + genLoadPtr |=> genLoadPtr == $past(genLoadPtr) + 8'h01)
      else $error("general pointer step");
   AST_UNLOAD: assert property (genUnloadStep && !clr |=> genUnloadPtr == $past(genUnloadPtr) + 8'h01)
      else $error("unload pointer step");
   AST_CLEAR: assert property (clr |=> {priLoadPtr, genLoadPtr, priUnloadPtr, genUnloadPtr} == 30'h0000_0000)
      else $error("pointers not cleared");
endmodule
bind cat_loader cat_loader_monitor u_mon (.clk_sys, .rst_n, .ctlClear, .tapeLoad, .genUnloadStep,
   .memReq, .memWe, .memGnt, .txLoad, .rxTaken, .memAddr, .memWdata, .memRdata, .rxCharBus,
   .txChar, .svcSlot, .genLoadPtr, .genUnloadPtr, .priLoadPtr, .priUnloadPtr);

// ### tb/cat_mem_model.sv
// Shared core memory model: grants each access after a random wait.
// Assumes the loader holds one request at a time until granted.
`timescale 1ns/1ps
module cat_mem_model (
   // Clock and reset
   input logic clk_sys, rst_n,
   // Loader side of the shared bus
   input logic memReq, memWe,
   input logic [15:0] memAddr,
   output logic memGnt = 1'b0,
   output logic [31:0] memRdata
);
   logic [2:0] waitCnt_q;
   // Buffer word per slot: lane k holds slot xor k*41h
   wire [7:0] s = memAddr[7:0];
   wire [31:0] word = {s ^ 8'hC3, s ^ 8'h82, s ^ 8'h41, s};
   // Inverse outside a read grant so stale data never matches
   assign memRdata = (memGnt && !memWe) ? word : ~word;
   // Bus is time shared, so the wait varies per access
   always @(posedge clk_sys) begin
      if (!rst_n || !memReq || memGnt) begin
         memGnt <= 1'b0;
         waitCnt_q <= 3'($urandom % 5);
      end else if (waitCnt_q == 3'h0) begin
         memGnt <= 1'b1;
      end else begin
         waitCnt_q <= waitCnt_q - 3'h1;
      end
   end
endmodule

// ### tb/channel_activity_table_loader_tb.sv
// Self-checking bench for the activity table loader.
// Assumes the memory model answers every access within a few cycles.
`timescale 1ns/1ps
module channel_activity_table_loader_tb;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic ctlClear = 1'b0;
   logic tapeLoad = 1'b0;
   logic priUnloadStep = 1'b0;
   logic genUnloadStep = 1'b0;
   logic [143:0] rxReady = 144'h0, txAvail = 144'h0, txHighSpeed = 144'h0;
   logic [8*144-1:0] rxCharBus = 1152'h0;
   logic memReq, memWe, memGnt, txLoad, rxTaken;
   logic [15:0] memAddr, wrAddr;
   logic [32:0] memWdata, wrWord;
   logic [31:0] memRdata;
   logic [7:0] txChar, svcSlot, genLoadPtr, genUnloadPtr, gotChar, genExp = 8'h00;
   logic [6:0] priLoadPtr, priUnloadPtr, priExp = 7'h00;
   int err_total = 0, check_count = 0, cyc = 0;
   always #5 clk_sys = ~clk_sys;
   cat_loader DUT (.clk_sys, .rst_n, .ctlClear, .tapeLoad, .priUnloadStep, .genUnloadStep,
      .rxReady, .txAvail, .txHighSpeed, .rxCharBus, .memReq, .memWe, .memAddr, .memWdata,
      .memRdata, .memGnt, .txChar, .txLoad, .rxTaken, .svcSlot, .priLoadPtr, .genLoadPtr,
      .priUnloadPtr, .genUnloadPtr);
   cat_mem_model u_mem (.clk_sys, .rst_n, .memReq, .memWe, .memAddr, .memGnt, .memRdata);
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      if (err_total == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   function automatic logic [7:0] lineAddr(input int s);
      return s < 128 ? 8'(s) : {4'(s), 4'h0};
   endfunction
   function automatic logic [7:0] bufChar(input logic [7:0] s);
      return s ^ (8'(s[1:0]) * 8'h41);
   endfunction
   // One slot service: raise flag, watch delivery and table write
   task automatic svc(input int s, input bit rx, input bit hs);
      logic [7:0] ch;
      logic gotRx;
      ch = 8'($urandom); // Parity bit is random, never checked
      gotRx = 1'b0;
      gotChar = ~bufChar(8'(s));
      wrAddr = 16'h0000;
      rxCharBus[8*s +: 8] = ch;
      txHighSpeed[s] = hs;
      rxReady[s] = rx;
      txAvail[s] = !rx;
      for (int n = 0; n < 300 && wrAddr == 16'h0000; n++) begin
         @(negedge clk_sys);
         if (txLoad === 1'b1) gotChar = txChar;
         if (rxTaken === 1'b1) gotRx = 1'b1;
         if (memReq && memWe && memGnt) begin
            wrAddr = memAddr;
            wrWord = memWdata;
         end
      end
      rxReady[s] = 1'b0;
      txAvail[s] = 1'b0;
      @(negedge clk_sys);
      if (!rx) chk(gotChar, bufChar(8'(s)));
      chk(gotRx, rx);
      chk(wrWord[32:1], {15'h0000, !rx, lineAddr(s), rx ? ch : 8'h00});
      if (!rx && hs) begin
         chk(wrAddr, 16'h0100 + priExp);
         priExp++;
      end else begin
         chk(wrAddr, 16'h0200 + genExp);
         genExp++;
      end
      chk({priLoadPtr, genLoadPtr}, {priExp, genExp});
   endtask
   // Hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         final_report;
      end
   end
   initial begin
      void'($urandom(4520));
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      chk({priLoadPtr, genLoadPtr, priUnloadPtr, genUnloadPtr}, 33'h0);
      svc(128, 1, 0);
      svc(129, 0, 0);
      svc(143, 1, 1);
      svc(127, 0, 1);
      for (int i = 0; i < 420; i++) svc($urandom % 144, $urandom % 2, $urandom % 4 != 0);
      // Unload strobes, one cycle each
      for (int i = 0; i < 10; i++) begin
         genUnloadStep = !i[0];
         priUnloadStep = i % 4 == 0;
         @(negedge clk_sys);
      end
      chk({priUnloadPtr, genUnloadPtr}, {7'h03, 8'h05});
      // Clear, then tape load, each returns all pointers to start
      for (int k = 0; k < 2; k++) begin
         svc(5, 0, 1);
         ctlClear = k == 0;
         tapeLoad = k == 1;
         @(negedge clk_sys);
         ctlClear = 1'b0;
         tapeLoad = 1'b0;
         @(negedge clk_sys);
         chk({priLoadPtr, genLoadPtr, priUnloadPtr, genUnloadPtr}, 33'h0);
         priExp = 7'h00;
         genExp = 8'h00;
      end
      svc(7, 1, 0);
      final_report;
   end
endmodule
